// [pse_cfg_pkg.sv]
package pse_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HW_FLAG_ADDR    = 8'h1C;
  localparam logic [7:0] WD_COUNT_ADDR   = 8'h1E;
  localparam logic [7:0] SWITCH_MODE_ADDR = 8'h1F;
  localparam logic [7:0] PROG1_ADDR      = 8'h23;
  localparam logic [7:0] PROG2_ADDR      = 8'h27;
  localparam logic [7:0] PROG3_ADDR      = 8'h28;

  localparam logic [7:0] SWITCH_MODE_RST = 8'h00;
  localparam logic [7:0] PROG1_RST       = 8'h04;
  localparam logic [7:0] PROG2_RST       = 8'h47;
  localparam logic [7:0] PROG3_RST       = 8'h77;
  localparam logic [7:0] WD_COUNT_RST    = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WD_ENABLE_BIT   = 7;
  localparam int IRQ_ENABLE_BIT  = 6;
  localparam int FALLBACK_MSB    = 3;
  localparam int GATE_MSB        = 7;
  localparam int GATE_LSB        = 5;
  localparam int DET_SKIP_BIT    = 4;
  localparam int OSC_IGNORE_BIT  = 3;
  localparam int AC_MSB          = 2;
  localparam int TRIP_MSB        = 7;
  localparam int TRIP_LSB        = 4;
  localparam int DISC_MSB        = 3;
  localparam int FAULT_MSB       = 7;
  localparam int FAULT_LSB       = 4;
  localparam int START_MSB       = 3;

  localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
  localparam logic [1:0] MODE_AUTO     = 2'b11;

  // ----------------------------------------------------------------
  // timing: one 10 us base tick drives every interval
  // ----------------------------------------------------------------
  localparam int CLOCK_NS        = 20;
  localparam int BASE_TICK_NS    = 10000;
  localparam int BASE_CYCLES     = BASE_TICK_NS / CLOCK_NS;
  localparam int BASE_TICK_US    = BASE_TICK_NS / 1000;
  localparam int WD_PERIOD_US    = 164000;
  localparam int WD_TICKS        = WD_PERIOD_US / BASE_TICK_US;
  localparam int DISC_BASE_US    = 238000;
  localparam int DISC_STEP_US    = 16000;
  localparam int FAULT_BASE_US   = 40960;
  localparam int FAULT_STEP_US   = 2720;
  localparam logic [19:0] DISC_BASE_T  = 20'(DISC_BASE_US / BASE_TICK_US);
  localparam logic [19:0] DISC_STEP_T  = 20'(DISC_STEP_US / BASE_TICK_US);
  localparam logic [19:0] FAULT_BASE_T = 20'(FAULT_BASE_US / BASE_TICK_US);
  localparam logic [19:0] FAULT_STEP_T = 20'(FAULT_STEP_US / BASE_TICK_US);

  // ----------------------------------------------------------------
  // analog codes: gate in nA, ac in 10 nA, voltages in 10 uV
  // ----------------------------------------------------------------
  localparam logic [15:0] GATE_BASE_NA = 16'hC350;
  localparam logic [15:0] GATE_STEP_NA = 16'h186A;
  localparam logic [15:0] AC_BASE      = 16'h5378;
  localparam logic [15:0] AC_STEP      = 16'h0B11;
  localparam logic [15:0] TRIP_BASE    = 16'h34BC;
  localparam logic [15:0] TRIP_STEP    = 16'h0785;
  localparam logic [31:0] FAULT_PCT    = 32'h00000058;
  localparam logic [31:0] PCT_FULL     = 32'h00000064;

endpackage

// [pse_watchdog_timing_config.sv]
// How it works
// - enable bit arms watchdog takeover
// - irq when enabled and any flag set
// - expiry applies per port fallback bit
// - fallback writes mode 00 or 11
// - switch mode register resets to zero
// - gate current is 50uA minus 6.25 steps
// - ac threshold 213.68uA plus 28.33 steps
// - refuse auto power on skipped detection
// - program register one resets to 04h
// - trip voltage 135mV plus 19.25mV steps
// - fault limit is 88 percent trip
// - disconnect nominal 238ms plus 16ms steps
// - program register two resets to 47h
// - disconnect multiplier scales, 11b doubles
// - fault and startup 40.96ms plus 2.72ms
// - program register three resets to 77h
// - fault multiplier scales, 11b quadruples
// - counter decrements every 164ms, zero expires
// - hardware mode blocks software requests, sets flags
`timescale 1ns/1ns
module pse_watchdog_timing_config #(
  parameter int BASE_CYCLES = pse_cfg_pkg::BASE_CYCLES,
  parameter int WD_TICKS    = pse_cfg_pkg::WD_TICKS
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata_r,
  input  wire logic [1:0]  disconnect_multiplier,
  input  wire logic [1:0]  fault_multiplier,
  input  wire logic [1:0]  startup_multiplier,
  input  wire logic        osc_fault_status,
  input  wire logic [3:0]  sw_power_on_req,
  input  wire logic [3:0]  sw_mode_write,
  input  wire logic [7:0]  sw_mode_data,
  input  wire logic [3:0]  auto_power_req,
  input  wire logic [3:0]  auto_detect_skipped,
  output logic [7:0]       port_mode_r,
  output logic [3:0]       power_on_r,
  output logic             hw_mode_r,
  output logic             takeover_irq_r,
  output logic             osc_fault_r,
  output logic             base_tick_r,
  output logic [15:0]      gate_pullup_current_r,
  output logic [15:0]      ac_threshold_r,
  output logic [15:0]      trip_voltage_r,
  output logic [15:0]      fault_limit_voltage_r,
  output logic [19:0]      disconnect_time_r,
  output logic [19:0]      fault_timeout_r,
  output logic [19:0]      startup_timeout_r
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  switch_mode_r;
  logic [7:0]  prog1_r;
  logic [7:0]  prog2_r;
  logic [7:0]  prog3_r;
  logic [7:0]  watchdog_count_r;
  logic [3:0]  port_hw_control_flag_r;
  logic [15:0] base_cnt_r;
  logic [15:0] wd_cnt_r;
  logic        wd_step;
  logic        expiry;
  logic        flag_read;
  logic [3:0]  denied;

  wire logic watchdog_enable     = switch_mode_r[pse_cfg_pkg::WD_ENABLE_BIT];
  wire logic takeover_irq_enable = switch_mode_r[pse_cfg_pkg::IRQ_ENABLE_BIT];
  wire logic [3:0] port_fallback_select = switch_mode_r[pse_cfg_pkg::FALLBACK_MSB:0];
  wire logic detect_skip_allow   = prog1_r[pse_cfg_pkg::DET_SKIP_BIT];
  wire logic osc_fault_ignore    = prog1_r[pse_cfg_pkg::OSC_IGNORE_BIT];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      switch_mode_r <= pse_cfg_pkg::SWITCH_MODE_RST;
      prog1_r       <= pse_cfg_pkg::PROG1_RST;
      prog2_r       <= pse_cfg_pkg::PROG2_RST;
      prog3_r       <= pse_cfg_pkg::PROG3_RST;
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        pse_cfg_pkg::SWITCH_MODE_ADDR: switch_mode_r <= reg_wdata;
        pse_cfg_pkg::PROG1_ADDR:       prog1_r <= reg_wdata;
        pse_cfg_pkg::PROG2_ADDR:       prog2_r <= reg_wdata;
        pse_cfg_pkg::PROG3_ADDR:       prog3_r <= reg_wdata;
        default:                       ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      reg_rdata_r <= 8'h00;
    else if (reg_read)
    begin
      unique case (reg_addr)
        pse_cfg_pkg::HW_FLAG_ADDR:     reg_rdata_r <= {4'h0, port_hw_control_flag_r};
        pse_cfg_pkg::WD_COUNT_ADDR:    reg_rdata_r <= watchdog_count_r;
        pse_cfg_pkg::SWITCH_MODE_ADDR: reg_rdata_r <= switch_mode_r;
        pse_cfg_pkg::PROG1_ADDR:       reg_rdata_r <= prog1_r;
        pse_cfg_pkg::PROG2_ADDR:       reg_rdata_r <= prog2_r;
        pse_cfg_pkg::PROG3_ADDR:       reg_rdata_r <= prog3_r;
        default:                       reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // base tick and watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      base_cnt_r  <= 16'h0000;
      base_tick_r <= 1'b0;
    end
    else if (base_cnt_r == 16'(BASE_CYCLES - 1))
    begin
      base_cnt_r  <= 16'h0000;
      base_tick_r <= 1'b1;
    end
    else
    begin
      base_cnt_r  <= base_cnt_r + 16'h0001;
      base_tick_r <= 1'b0;
    end
  end

  // watchdog period counted in base ticks, restarted while disabled
  always_ff @(posedge clock)
  begin
    if (reset || !watchdog_enable)
      wd_cnt_r <= 16'h0000;
    else if (base_tick_r)
      wd_cnt_r <= (wd_cnt_r == 16'(WD_TICKS - 1)) ? 16'h0000 : wd_cnt_r + 16'h0001;
  end

  assign wd_step = watchdog_enable && base_tick_r && (wd_cnt_r == 16'(WD_TICKS - 1));
  // counter at zero while armed is expiry; any write to the counter the same cycle wins
  assign expiry  = watchdog_enable && !hw_mode_r && (watchdog_count_r == 8'h00)
                   && !(reg_write && reg_addr == pse_cfg_pkg::WD_COUNT_ADDR);

  always_ff @(posedge clock)
  begin
    if (reset)
      watchdog_count_r <= pse_cfg_pkg::WD_COUNT_RST;
    else if (reg_write && reg_addr == pse_cfg_pkg::WD_COUNT_ADDR)
      watchdog_count_r <= reg_wdata;
    else if (wd_step && watchdog_count_r != 8'h00)
      watchdog_count_r <= watchdog_count_r - 8'h01;
  end

  // leaving hardware control takes clearing the enable bit
  always_ff @(posedge clock)
  begin
    if (reset || !watchdog_enable)
      hw_mode_r <= 1'b0;
    else if (expiry)
      hw_mode_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // port modes and power requests
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_port
      always_ff @(posedge clock)
      begin
        if (reset)
          port_mode_r[2*p+1:2*p] <= pse_cfg_pkg::MODE_SHUTDOWN;
        else if (expiry)
          port_mode_r[2*p+1:2*p] <= port_fallback_select[p] ? pse_cfg_pkg::MODE_AUTO
                                                             : pse_cfg_pkg::MODE_SHUTDOWN;
        else if (sw_mode_write[p] && !hw_mode_r)
          port_mode_r[2*p+1:2*p] <= sw_mode_data[2*p+1:2*p];
      end

      always_comb
      begin
        denied[p] = sw_power_on_req[p] && hw_mode_r;
      end

      always_ff @(posedge clock)
      begin
        if (reset)
          power_on_r[p] <= 1'b0;
        else
          power_on_r[p] <= (sw_power_on_req[p] && !hw_mode_r)
                           || (auto_power_req[p] && port_mode_r[2*p+1:2*p] == pse_cfg_pkg::MODE_AUTO
                               && (detect_skip_allow || !auto_detect_skipped[p]));
      end
    end
  endgenerate

  assign flag_read = reg_read && reg_addr == pse_cfg_pkg::HW_FLAG_ADDR;

  // clear on read; a new takeover or denial in that cycle still lands
  always_ff @(posedge clock)
  begin
    if (reset)
      port_hw_control_flag_r <= 4'h0;
    else
      port_hw_control_flag_r <= (flag_read ? 4'h0 : port_hw_control_flag_r)
                                | (expiry ? 4'hF : 4'h0) | denied;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      takeover_irq_r <= 1'b0;
      osc_fault_r    <= 1'b0;
    end
    else
    begin
      takeover_irq_r <= takeover_irq_enable && (port_hw_control_flag_r != 4'h0);
      osc_fault_r    <= osc_fault_status && !osc_fault_ignore;
    end
  end

  // ----------------------------------------------------------------
  // programmed thresholds and times
  // ----------------------------------------------------------------
  logic [19:0] disc_nom;
  logic [19:0] fault_nom;
  logic [19:0] start_nom;
  logic [21:0] disc_scaled;
  logic [21:0] fault_scaled;
  logic [21:0] start_scaled;
  logic [15:0] trip_nxt;
  logic [31:0] fault_lim_wide;

  always_comb
  begin
    disc_nom  = pse_cfg_pkg::DISC_BASE_T
                + 20'(pse_cfg_pkg::DISC_STEP_T * prog2_r[pse_cfg_pkg::DISC_MSB:0]);
    fault_nom = pse_cfg_pkg::FAULT_BASE_T
                + 20'(pse_cfg_pkg::FAULT_STEP_T * prog3_r[pse_cfg_pkg::FAULT_MSB:pse_cfg_pkg::FAULT_LSB]);
    start_nom = pse_cfg_pkg::FAULT_BASE_T
                + 20'(pse_cfg_pkg::FAULT_STEP_T * prog3_r[pse_cfg_pkg::START_MSB:0]);
    disc_scaled  = {2'b00, disc_nom} << disconnect_multiplier;
    fault_scaled = {2'b00, fault_nom} << fault_multiplier;
    start_scaled = {2'b00, start_nom} << startup_multiplier;
    trip_nxt = pse_cfg_pkg::TRIP_BASE
               + 16'(pse_cfg_pkg::TRIP_STEP * prog2_r[pse_cfg_pkg::TRIP_MSB:pse_cfg_pkg::TRIP_LSB]);
    fault_lim_wide = ({16'h0000, trip_nxt} * pse_cfg_pkg::FAULT_PCT) / pse_cfg_pkg::PCT_FULL;
  end

  // consumers latch these when a timer starts, so running timers keep their length
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      gate_pullup_current_r <= 16'h0000;
      ac_threshold_r        <= 16'h0000;
      trip_voltage_r        <= 16'h0000;
      fault_limit_voltage_r <= 16'h0000;
      disconnect_time_r     <= 20'h00000;
      fault_timeout_r       <= 20'h00000;
      startup_timeout_r     <= 20'h00000;
    end
    else
    begin
      gate_pullup_current_r <= pse_cfg_pkg::GATE_BASE_NA
                               - 16'(pse_cfg_pkg::GATE_STEP_NA * prog1_r[pse_cfg_pkg::GATE_MSB:pse_cfg_pkg::GATE_LSB]);
      ac_threshold_r        <= pse_cfg_pkg::AC_BASE
                               + 16'(pse_cfg_pkg::AC_STEP * prog1_r[pse_cfg_pkg::AC_MSB:0]);
      trip_voltage_r        <= trip_nxt;
      fault_limit_voltage_r <= fault_lim_wide[15:0];
      disconnect_time_r     <= disc_scaled[21:2];
      fault_timeout_r       <= fault_scaled[20:1];
      startup_timeout_r     <= start_scaled[20:1];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_no_takeover_off: assert property (!watchdog_enable |=> !hw_mode_r)
    else $error("hardware mode while watchdog disabled");
  chk_irq_follows_flags: assert property
    (takeover_irq_enable && port_hw_control_flag_r != 4'h0 |=> takeover_irq_r)
    else $error("takeover irq missing");
  chk_fallback_mode: assert property
    (expiry |=> port_mode_r[1:0] == ($past(port_fallback_select[0]) ? pse_cfg_pkg::MODE_AUTO : pse_cfg_pkg::MODE_SHUTDOWN))
    else $error("fallback mode wrong");
  chk_skip_refused: assert property
    (auto_power_req[0] && auto_detect_skipped[0] && !detect_skip_allow && !sw_power_on_req[0]
     |=> !power_on_r[0])
    else $error("power on after skipped detection");
  chk_osc_ignored: assert property (osc_fault_ignore |=> !osc_fault_r)
    else $error("oscillator fault not ignored");
  chk_fault_pct: assert property
    (fault_limit_voltage_r == 16'((32'(trip_voltage_r) * pse_cfg_pkg::FAULT_PCT) / pse_cfg_pkg::PCT_FULL))
    else $error("fault limit not 88 percent");
  chk_disc_double: assert property
    (disconnect_multiplier == 2'h3 |=> disconnect_time_r == 20'(2 * 32'($past(disc_nom))))
    else $error("disconnect not doubled");
  chk_fault_quad: assert property
    (fault_multiplier == 2'h3 |=> fault_timeout_r == 20'(4 * 32'($past(fault_nom))))
    else $error("fault timeout not quadrupled");
  chk_wd_decrement: assert property
    (wd_step && watchdog_count_r != 8'h00 && !reg_write |=> watchdog_count_r == $past(watchdog_count_r) - 8'h01)
    else $error("watchdog count did not step");
  chk_mode_locked: assert property
    (hw_mode_r && !expiry |=> $stable(port_mode_r))
    else $error("mode changed under hardware control");
  chk_denial_flag: assert property (denied[1] |=> port_hw_control_flag_r[1])
    else $error("denied request not flagged");

  cov_takeover: cover property (expiry ##1 hw_mode_r);
  cov_denied: cover property (hw_mode_r && sw_power_on_req != 4'h0);
  cov_irq: cover property (takeover_irq_r);
  cov_flag_read: cover property (flag_read && port_hw_control_flag_r != 4'h0);

endmodule

// [pse_watchdog_timing_config_tb.sv]
`timescale 1ns/1ns
module pse_watchdog_timing_config_tb;
  logic        clock;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata_r;
  logic [1:0]  dm;
  logic [1:0]  fm;
  logic [1:0]  sm;
  logic        osc_st;
  logic [3:0]  sw_pwr;
  logic [3:0]  sw_mw;
  logic [7:0]  sw_md;
  logic [3:0]  auto_req;
  logic [3:0]  skipped;
  logic [7:0]  port_mode_r;
  logic [3:0]  power_on_r;
  logic        hw_mode_r;
  logic        irq_r;
  logic        osc_r;
  logic        tick_r;
  logic [15:0] gate_r;
  logic [15:0] ac_r;
  logic [15:0] trip_r;
  logic [15:0] flim_r;
  logic [19:0] disc_r;
  logic [19:0] fault_r;
  logic [19:0] start_r;
  logic [7:0]  d;
  int          n_mismatch;
  int          total_checks;

  // small counts keep the watchdog run short: 4 cycles a tick, 3 ticks a step
  pse_watchdog_timing_config #(.BASE_CYCLES(4), .WD_TICKS(3)) pse_watchdog_timing_config_inst (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_r(reg_rdata_r),
    .disconnect_multiplier(dm), .fault_multiplier(fm), .startup_multiplier(sm),
    .osc_fault_status(osc_st), .sw_power_on_req(sw_pwr), .sw_mode_write(sw_mw),
    .sw_mode_data(sw_md), .auto_power_req(auto_req), .auto_detect_skipped(skipped),
    .port_mode_r(port_mode_r), .power_on_r(power_on_r), .hw_mode_r(hw_mode_r),
    .takeover_irq_r(irq_r), .osc_fault_r(osc_r), .base_tick_r(tick_r),
    .gate_pullup_current_r(gate_r), .ac_threshold_r(ac_r), .trip_voltage_r(trip_r),
    .fault_limit_voltage_r(flim_r), .disconnect_time_r(disc_r),
    .fault_timeout_r(fault_r), .startup_timeout_r(start_r));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    v = reg_rdata_r;
  endtask

  task automatic sw_mode(input logic [7:0] v);
    @(negedge clock);
    sw_mw = 4'hF;
    sw_md = v;
    @(negedge clock);
    sw_mw = 4'h0;
  endtask

  task automatic wait_hw(input logic lvl);
    int i;
    for (i = 0; i < 60 && hw_mode_r !== lvl; i++)
      @(negedge clock);
    if (hw_mode_r !== lvl)
    begin
      n_mismatch++;
      $display("[ERR] hw_mode wait ran out");
      results();
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // every expectation worked from field codes and tick units of 10 us
  task automatic check_outputs(input logic [7:0] p1, p2, p3);
    int t;
    t = 13500 + 1925 * p2[7:4];
    chk_val("gate", 20'(50000 - 6250 * p1[7:5]), 20'(gate_r));
    chk_val("ac", 20'(21368 + 2833 * p1[2:0]), 20'(ac_r));
    chk_val("trip", 20'(t), 20'(trip_r));
    chk_val("flim", 20'(t * 88 / 100), 20'(flim_r));
    chk_val("disc", 20'(((23800 + 1600 * p2[3:0]) << dm) >> 2), disc_r);
    chk_val("fault", 20'(((4096 + 272 * p3[7:4]) << fm) >> 1), fault_r);
    chk_val("start", 20'(((4096 + 272 * p3[3:0]) << sm) >> 1), start_r);
  endtask

  task automatic reset_values();
    rd(pse_cfg_pkg::SWITCH_MODE_ADDR, d);
    chk_val("r1F", 20'(8'h00), 20'(d));
    rd(pse_cfg_pkg::PROG1_ADDR, d);
    chk_val("r23", 20'(8'h04), 20'(d));
    rd(pse_cfg_pkg::PROG2_ADDR, d);
    chk_val("r27", 20'(8'h47), 20'(d));
    rd(pse_cfg_pkg::PROG3_ADDR, d);
    chk_val("r28", 20'(8'h77), 20'(d));
    rd(8'h30, d);
    chk_val("unmapped", 20'(8'h00), 20'(d));
    check_outputs(8'h04, 8'h47, 8'h77);
  endtask

  task automatic num_case(input logic [7:0] p1, p2, p3, input logic [1:0] a, b, c);
    wr(pse_cfg_pkg::PROG1_ADDR, p1);
    wr(pse_cfg_pkg::PROG2_ADDR, p2);
    wr(pse_cfg_pkg::PROG3_ADDR, p3);
    dm = a;
    fm = b;
    sm = c;
    tick(2);
    rd(pse_cfg_pkg::PROG2_ADDR, d);
    chk_val("r27 back", 20'(p2), 20'(d));
    check_outputs(p1, p2, p3);
  endtask

  task automatic base_tick();
    int i;
    for (i = 0; i < 10 && tick_r !== 1'b1; i++)
      @(negedge clock);
    if (tick_r !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] base_tick wait ran out");
      results();
    end
    for (i = 1; i <= 4; i++)
    begin
      @(negedge clock);
      chk_bit("base_tick", i == 4, tick_r);
    end
  endtask

  task automatic osc_and_detect();
    osc_st = 1'b1;
    wr(pse_cfg_pkg::PROG1_ADDR, 8'h04);
    tick(2);
    chk_bit("osc shown", 1'b1, osc_r);
    wr(pse_cfg_pkg::PROG1_ADDR, 8'h0C);
    tick(2);
    chk_bit("osc ignored", 1'b0, osc_r);
    sw_mode(8'h03);
    skipped = 4'h1;
    wr(pse_cfg_pkg::PROG1_ADDR, 8'h04);
    @(negedge clock) auto_req = 4'h1;
    @(negedge clock) auto_req = 4'h0;
    chk_bit("skip refused", 1'b0, power_on_r[0]);
    wr(pse_cfg_pkg::PROG1_ADDR, 8'h14);
    @(negedge clock) auto_req = 4'h1;
    @(negedge clock) auto_req = 4'h0;
    chk_bit("skip allowed", 1'b1, power_on_r[0]);
  endtask

  task automatic watchdog();
    sw_mode(8'h55);
    wr(pse_cfg_pkg::WD_COUNT_ADDR, 8'h00);
    wr(pse_cfg_pkg::SWITCH_MODE_ADDR, 8'h4F);
    tick(40);
    chk_bit("hw while disabled", 1'b0, hw_mode_r);
    chk_val("mode while disabled", 20'(8'h55), 20'(port_mode_r));
    wr(pse_cfg_pkg::WD_COUNT_ADDR, 8'h02);
    wr(pse_cfg_pkg::SWITCH_MODE_ADDR, 8'hC5);
    tick(8);
    chk_bit("hw early", 1'b0, hw_mode_r);
    wait_hw(1'b1);
    chk_val("fallback", 20'(8'h33), 20'(port_mode_r));
    tick(2);
    chk_bit("irq on", 1'b1, irq_r);
    wr(pse_cfg_pkg::WD_COUNT_ADDR, 8'hFF);
    rd(pse_cfg_pkg::HW_FLAG_ADDR, d);
    chk_val("flags", 20'(8'h0F), 20'(d));
    rd(pse_cfg_pkg::HW_FLAG_ADDR, d);
    chk_val("flags cleared", 20'(8'h00), 20'(d));
    sw_mode(8'hFF);
    chk_val("mode locked", 20'(8'h33), 20'(port_mode_r));
    @(negedge clock) sw_pwr = 4'h2;
    @(negedge clock) sw_pwr = 4'h0;
    chk_bit("power denied", 1'b0, power_on_r[1]);
    rd(pse_cfg_pkg::HW_FLAG_ADDR, d);
    chk_val("denied flag", 20'(8'h02), 20'(d));
    wr(pse_cfg_pkg::SWITCH_MODE_ADDR, 8'h00);
    wait_hw(1'b0);
    sw_mode(8'hFF);
    chk_val("mode free", 20'(8'hFF), 20'(port_mode_r));
    // count written to zero, so enabling takes over at once; irq bit left off
    wr(pse_cfg_pkg::WD_COUNT_ADDR, 8'h00);
    wr(pse_cfg_pkg::SWITCH_MODE_ADDR, 8'h8A);
    wait_hw(1'b1);
    chk_val("fallback2", 20'(8'hCC), 20'(port_mode_r));
    tick(3);
    chk_bit("irq off", 1'b0, irq_r);
    @(negedge clock) reset = 1'b1;
    tick(2);
    reset = 1'b0;
    rd(pse_cfg_pkg::SWITCH_MODE_ADDR, d);
    chk_val("r1F again", 20'(8'h00), 20'(d));
    chk_bit("hw after reset", 1'b0, hw_mode_r);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    dm = 2'h2;
    fm = 2'h1;
    sm = 2'h1;
    osc_st = 1'b0;
    sw_pwr = 4'h0;
    sw_mw = 4'h0;
    sw_md = 8'h00;
    auto_req = 4'h0;
    skipped = 4'h0;
    tick(6);
    reset = 1'b0;
    reset_values();
    num_case(8'hE7, 8'hFF, 8'hF0, 2'h3, 2'h3, 2'h0);
    num_case(8'hA3, 8'h0A, 8'h5C, 2'h0, 2'h2, 2'h1);
    num_case(8'h40, 8'h91, 8'h0F, 2'h1, 2'h0, 2'h3);
    base_tick();
    osc_and_detect();
    watchdog();
    results();
  end
endmodule
